// >>> css_regs.svh
`ifndef CSS_REGS_SVH
`define CSS_REGS_SVH
// register byte offsets
`define CSS_ADDR_CTRL 12'h000
`define CSS_ADDR_STAT 12'h004
`define CSS_ADDR_ERRCODE 12'h008
`define CSS_ADDR_LOGPTR 12'h00c
`define CSS_ADDR_ERRIN 12'h010
`define CSS_ADDR_DETAIL 12'h014
`define CSS_ADDR_TIME 12'h018
`define CSS_ADDR_LOGBASE 12'h100
// control fields
`define CSS_CTRL_OUT_OFF 0
`define CSS_CTRL_PTR_RST 1
`define CSS_CTRL_WAIT_CFG 2
`define CSS_CTRL_BOARD_CFG 3
`define CSS_CTRL_IOM_HOLD 4
`define CSS_CTRL_USER_FAL 5
`define CSS_CTRL_USER_FALS 6
// status fields
`define CSS_STAT_BUSY 0
`define CSS_STAT_FLASH_ERR 1
`define CSS_STAT_RUNNING 2
`define CSS_STAT_HALTED 3
`define CSS_STAT_NONFATAL 4
// log geometry
`define CSS_LOG_RECS 20
`define CSS_REC_WORDS 5
`define CSS_LOG_WORDS 100
// words restored from flash at power-up
`define CSS_RESTORE_WORDS 16'h0100
// user alarm codes
`define CSS_CODE_FAL 16'h4100
`define CSS_CODE_FALS 16'hc100
`endif

// >>> css_pkg.sv
package css_pkg;
    typedef enum logic [4:0] {
        CSS_RESTORE = 5'b00001,
        CSS_WAIT = 5'b00010,
        CSS_IDLE = 5'b00100,
        CSS_BACKUP = 5'b01000,
        CSS_FAIL = 5'b10000
    } css_state_t;
endpackage

// >>> css_supervisor.sv
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "css_regs.svh"

module css_supervisor
    import css_pkg::*;
(
    // clock and reset
    input wire logic MCLK_I,
    input wire logic RESET_I,
    input wire logic CE_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // programming tool side
    input wire logic PROG_WR_I,
    input wire logic [15:0] PROG_SIZE_I,
    // flash port
    output logic FLASH_WR_O,
    output logic FLASH_RD_O,
    output logic [15:0] FLASH_ADDR_O,
    input wire logic FLASH_DONE_I,
    input wire logic FLASH_FAIL_I,
    // backplane
    input wire logic UNITS_READY_I,
    input wire logic BOARDS_READY_I,
    input wire logic [1:0] MODE_I,
    input wire logic SYS_ERR_I,
    input wire logic SYS_FATAL_I,
    input wire logic [15:0] SYS_CODE_I,
    input wire logic [31:0] SYS_DETAIL_I,
    input wire logic [31:0] TIME_I,
    input wire logic [15:0] OUT_REQ_I,
    // status
    output logic BACKUP_BUSY_LAMP_O,
    output logic RUN_ENABLE_O,
    output logic [15:0] OUTPUTS_O
);
    localparam logic [1:0] MODE_PROG = 2'h0;

    css_state_t state_r;
    logic [15:0] cnt_r;
    logic [15:0] len_r;
    logic pend_r;
    logic flash_err_r;
    logic halted_r;
    logic nonfatal_r;
    logic [6:0] ctrl_r;
    logic [15:0] code_r;
    logic [4:0] ptr_r;
    logic [31:0] detail_r;
    logic [31:0] time_r;
    logic [31:0] log_mem [0:`CSS_LOG_WORDS-1];
    logic [1:0] mode_prev_r;
    logic blank_r;
    logic [15:0] out_r;
    logic [31:0] rdata_r;

    logic wr_acc, rd_acc;
    logic user_fal, user_fals, err_ev;
    logic [15:0] ev_code;
    logic [31:0] ev_detail;
    logic log_full;
    logic [6:0] top;

    assign wr_acc = PSEL_I && PENABLE_I && PWRITE_I;
    assign rd_acc = PSEL_I && !PENABLE_I && !PWRITE_I;
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = 1'b0;

    // user alarms are write strobes into the control word
    assign user_fal = CE_I && wr_acc && PADDR_I == `CSS_ADDR_CTRL
        && PWDATA_I[`CSS_CTRL_USER_FAL];
    assign user_fals = CE_I && wr_acc && PADDR_I == `CSS_ADDR_CTRL
        && PWDATA_I[`CSS_CTRL_USER_FALS];
    assign err_ev = (CE_I && SYS_ERR_I) || user_fal || user_fals;
    // system error wins when it coincides with a user alarm
    always_comb begin
        if (SYS_ERR_I) begin
            ev_code = SYS_CODE_I;
            ev_detail = SYS_DETAIL_I;
        end else if (user_fals) begin
            ev_code = `CSS_CODE_FALS;
            ev_detail = PWDATA_I;
        end else begin
            ev_code = `CSS_CODE_FAL;
            ev_detail = PWDATA_I;
        end
    end
    assign log_full = ptr_r == 5'(`CSS_LOG_RECS);
    assign top = 7'(`CSS_LOG_WORDS - `CSS_REC_WORDS);

    // control word: settings plus pointer reset strobe
    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            ctrl_r <= 7'h00;
        end else if (CE_I && wr_acc && PADDR_I == `CSS_ADDR_CTRL) begin
            ctrl_r <= {2'b00, PWDATA_I[4:0]};
        end else if (CE_I) begin
            ctrl_r[`CSS_CTRL_PTR_RST] <= 1'b0;
        end
    end

    // backup sequencer; flash holds only program and parameter image
    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            state_r <= CSS_RESTORE;
            cnt_r <= 16'h0000;
            len_r <= 16'h0000;
            pend_r <= 1'b0;
        end else if (CE_I) begin
            case (state_r)
                CSS_RESTORE: begin
                    // copy flash into user memory before anything runs
                    if (FLASH_FAIL_I) begin
                        state_r <= CSS_FAIL;
                    end else if (FLASH_DONE_I) begin
                        cnt_r <= cnt_r + 16'h0001;
                        if (cnt_r == `CSS_RESTORE_WORDS - 16'h0001) begin
                            state_r <= CSS_WAIT;
                        end
                    end
                end
                CSS_WAIT: begin
                    if (!ctrl_r[`CSS_CTRL_WAIT_CFG]) begin
                        if (UNITS_READY_I && BOARDS_READY_I) begin
                            state_r <= CSS_IDLE;
                        end
                    end else if (BOARDS_READY_I || ctrl_r[`CSS_CTRL_BOARD_CFG]) begin
                        state_r <= CSS_IDLE;
                    end
                end
                CSS_IDLE: begin
                    if (PROG_WR_I || pend_r) begin
                        // length tracks program size
                        len_r <= PROG_SIZE_I;
                        cnt_r <= 16'h0000;
                        pend_r <= 1'b0;
                        if (!PROG_WR_I) begin
                            state_r <= CSS_BACKUP;
                        end else begin
                            pend_r <= 1'b1;
                        end
                    end
                end
                CSS_BACKUP: begin
                    if (PROG_WR_I) begin
                        // a new write restarts so flash ends with the latest image
                        pend_r <= 1'b1;
                        cnt_r <= 16'h0000;
                    end else if (FLASH_FAIL_I) begin
                        state_r <= CSS_FAIL;
                    end else if (pend_r) begin
                        pend_r <= 1'b0;
                        len_r <= PROG_SIZE_I;
                        cnt_r <= 16'h0000;
                    end else if (FLASH_DONE_I) begin
                        cnt_r <= cnt_r + 16'h0001;
                        if (cnt_r >= len_r) begin
                            state_r <= CSS_IDLE;
                        end
                    end
                end
                CSS_FAIL: begin
                    // stay here; a retry needs a fresh write
                    if (PROG_WR_I) begin
                        pend_r <= 1'b1;
                        state_r <= CSS_IDLE;
                    end
                end
                default: state_r <= CSS_RESTORE;
            endcase
        end
    end

    // flash port and lamp; the lamp also covers restore at power-up
    always_comb begin
        FLASH_WR_O = state_r == CSS_BACKUP && !pend_r && !PROG_WR_I;
        FLASH_RD_O = state_r == CSS_RESTORE;
        FLASH_ADDR_O = cnt_r;
        BACKUP_BUSY_LAMP_O = state_r == CSS_BACKUP || state_r == CSS_RESTORE
            || (state_r == CSS_IDLE && pend_r);
        RUN_ENABLE_O = !halted_r && (state_r == CSS_IDLE || state_r == CSS_BACKUP);
    end

    // sticky flash failure flag
    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            flash_err_r <= 1'b0;
        end else if (CE_I && FLASH_FAIL_I) begin
            flash_err_r <= 1'b1;
        end
    end

    // fatal alarms halt execution, non-fatal only flag
    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            halted_r <= 1'b0;
            nonfatal_r <= 1'b0;
        end else if (CE_I) begin
            if (user_fals || (SYS_ERR_I && SYS_FATAL_I)) begin
                halted_r <= 1'b1;
            end
            if (user_fal || (SYS_ERR_I && !SYS_FATAL_I)) begin
                nonfatal_r <= 1'b1;
            end
        end
    end

    // current code and pointer; event beats pointer reset
    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            code_r <= 16'h0000;
            ptr_r <= 5'h00;
        end else if (CE_I) begin
            if (err_ev) begin
                code_r <= ev_code;
                if (!log_full) begin
                    ptr_r <= ptr_r + 5'h01;
                end
            end else if (ctrl_r[`CSS_CTRL_PTR_RST]) begin
                ptr_r <= 5'h00;
            end
        end
    end

    // log array, five words per record
    always_ff @(posedge MCLK_I) begin
        if (CE_I && err_ev) begin
            if (log_full) begin
                for (int i = 0; i < `CSS_LOG_WORDS - `CSS_REC_WORDS; i++) begin
                    log_mem[i] <= log_mem[i + `CSS_REC_WORDS];
                end
                log_mem[top] <= {16'h0000, ev_code};
                log_mem[top + 7'd1] <= ev_detail;
                log_mem[top + 7'd2] <= TIME_I;
                log_mem[top + 7'd3] <= {31'h0, SYS_FATAL_I && SYS_ERR_I || user_fals};
                log_mem[top + 7'd4] <= 32'h0;
            end else begin
                log_mem[7'(ptr_r * 5)] <= {16'h0000, ev_code};
                log_mem[7'(ptr_r * 5 + 1)] <= ev_detail;
                log_mem[7'(ptr_r * 5 + 2)] <= TIME_I;
                log_mem[7'(ptr_r * 5 + 3)] <= {31'h0, SYS_FATAL_I && SYS_ERR_I || user_fals};
                log_mem[7'(ptr_r * 5 + 4)] <= 32'h0;
            end
        end
    end

    // output blanking: forced off or run-to-program without retain
    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            mode_prev_r <= MODE_PROG;
            blank_r <= 1'b1;
            out_r <= 16'h0000;
        end else if (CE_I) begin
            mode_prev_r <= MODE_I;
            if (MODE_I == MODE_PROG && mode_prev_r != MODE_PROG
                && !ctrl_r[`CSS_CTRL_IOM_HOLD]) begin
                blank_r <= 1'b1;
            end else if (MODE_I != MODE_PROG) begin
                blank_r <= 1'b0;
            end
            out_r <= (ctrl_r[`CSS_CTRL_OUT_OFF] || blank_r) ? 16'h0000 : OUT_REQ_I;
        end
    end
    assign OUTPUTS_O = out_r;

    // read mux registered in setup, valid in access phase
    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            rdata_r <= 32'h0;
        end else if (CE_I && rd_acc) begin
            case (PADDR_I)
                `CSS_ADDR_CTRL: rdata_r <= {25'h0, ctrl_r};
                `CSS_ADDR_STAT: rdata_r <= {27'h0, nonfatal_r, halted_r,
                    RUN_ENABLE_O, flash_err_r, BACKUP_BUSY_LAMP_O};
                `CSS_ADDR_ERRCODE: rdata_r <= {16'h0, code_r};
                `CSS_ADDR_LOGPTR: rdata_r <= {27'h0, ptr_r};
                `CSS_ADDR_DETAIL: rdata_r <= detail_r;
                `CSS_ADDR_TIME: rdata_r <= time_r;
                default: begin
                    if (PADDR_I >= `CSS_ADDR_LOGBASE
                        && PADDR_I < `CSS_ADDR_LOGBASE + 12'(4 * `CSS_LOG_WORDS)) begin
                        rdata_r <= log_mem[7'((PADDR_I - `CSS_ADDR_LOGBASE) >> 2)];
                    end else begin
                        rdata_r <= 32'h0;
                    end
                end
            endcase
        end
    end
    assign PRDATA_O = rdata_r;

    // detail and time of the latest error, readable beside its code
    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            detail_r <= 32'h0;
            time_r <= 32'h0;
        end else if (CE_I && err_ev) begin
            detail_r <= ev_detail;
            time_r <= TIME_I;
        end
    end

    // pointer, lamp, backup, flash flag, output, alarm, error code and startup checks
    a_ptr_sat: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        ptr_r <= 5'd20) else $error("pointer above twenty");
    a_ptr_step: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        CE_I && err_ev && !log_full |=> ptr_r == $past(ptr_r) + 5'd1)
        else $error("pointer did not step");
    a_ptr_clear: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        CE_I && !err_ev && ctrl_r[1] |=> ptr_r == 5'd0)
        else $error("pointer not cleared");
    a_ptr_hold: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        log_full && !ctrl_r[1] |=> ptr_r == 5'd20) else $error("pointer left twenty");
    a_lamp_busy: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        FLASH_WR_O |-> BACKUP_BUSY_LAMP_O) else $error("lamp off in backup");
    a_lamp_idle: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        state_r == CSS_IDLE && !pend_r |-> !BACKUP_BUSY_LAMP_O) else $error("lamp lit at rest");
    a_start_backup: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        CE_I && state_r == CSS_IDLE && PROG_WR_I |=> pend_r)
        else $error("write lost");
    a_flag_sticky: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        CE_I && FLASH_FAIL_I |=> flash_err_r [*2]) else $error("flag not held");
    a_out_forced: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        CE_I && ctrl_r[0] |=> OUTPUTS_O == 16'h0) else $error("outputs not off");
    a_out_blank: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        CE_I && MODE_I == MODE_PROG && mode_prev_r != MODE_PROG && !ctrl_r[4] ##1 CE_I
        |=> OUTPUTS_O == 16'h0000) else $error("outputs kept in program mode");
    a_fatal_halt: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        user_fals |=> !RUN_ENABLE_O) else $error("fatal did not halt");
    a_code_update: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        CE_I && err_ev |=> code_r == $past(ev_code)) else $error("error code not stored");
    a_restore_gate: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        state_r == CSS_RESTORE |-> !RUN_ENABLE_O) else $error("ran before restore");
    a_wait_hold: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        state_r == CSS_WAIT && !ctrl_r[2] && !UNITS_READY_I |=> state_r == CSS_WAIT)
        else $error("left standby early");
    // main scenarios reached
    c_backup_done: cover property (@(posedge MCLK_I) state_r == CSS_BACKUP ##1 state_r == CSS_IDLE);
    c_log_full: cover property (@(posedge MCLK_I) log_full && err_ev);
    c_restart: cover property (@(posedge MCLK_I) state_r == CSS_BACKUP && PROG_WR_I);
    c_restore_end: cover property (@(posedge MCLK_I) state_r == CSS_RESTORE ##1 state_r == CSS_WAIT);
    c_forced_off: cover property (@(posedge MCLK_I) ctrl_r[0] && OUT_REQ_I != 16'h0000);
endmodule

// >>> css_flash_model.sv
`timescale 1ns/1ps
module css_flash_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // flash request side
    input wire logic wr_i,
    input wire logic rd_i,
    // bench controls
    input wire logic slow_i,
    input wire logic fail_cmd_i,
    // flash answers
    output logic done_o,
    output logic fail_o
);
    int cnt;
    // one word per few cycles while a transfer is requested; slow mode stretches it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= 0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if ((wr_i || rd_i) && !done_o) begin
                cnt <= cnt + 1;
                if (cnt >= (slow_i ? 3 : 0)) begin
                    cnt <= 0;
                    done_o <= 1'b1;
                end
            end
        end
    end
    // failure pulse only when a scenario asks for it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) fail_o <= 1'b0;
        else fail_o <= fail_cmd_i;
    end
endmodule

// >>> css_supervisor_test.sv
`timescale 1ns/1ps
`include "css_regs.svh"
module css_supervisor_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic prog_wr = 1'b0;
    logic fwr, frd, fdone, ffail, lamp, run;
    logic [15:0] outs;
    logic units = 1'b0;
    logic boards = 1'b0;
    logic [1:0] mode = 2'h1;
    logic sys_err = 1'b0;
    logic [15:0] code = 16'h0;
    logic [31:0] tm = 32'h0;
    logic fail_cmd = 1'b0;
    logic slow = 1'b0;
    logic ce = 1'b1;
    logic sfatal = 1'b0;
    logic slverr;
    logic [15:0] faddr;
    logic [31:0] rd;
    logic [1:0] cfg [3] = '{2'h2, 2'h1, 2'h3};
    int fail_count = 0;
    int check_count = 0;
    int wdone = 0;
    int w0, n;

    css_supervisor dut_u (.MCLK_I(clk), .RESET_I(rst), .CE_I(ce), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(slverr), .PROG_WR_I(prog_wr),
        .PROG_SIZE_I(16'h0004), .FLASH_WR_O(fwr), .FLASH_RD_O(frd), .FLASH_ADDR_O(faddr),
        .FLASH_DONE_I(fdone), .FLASH_FAIL_I(ffail), .UNITS_READY_I(units),
        .BOARDS_READY_I(boards), .MODE_I(mode), .SYS_ERR_I(sys_err), .SYS_FATAL_I(sfatal),
        .SYS_CODE_I(code), .SYS_DETAIL_I({16'hd000, code}), .TIME_I(tm),
        .OUT_REQ_I(16'ha5c3), .BACKUP_BUSY_LAMP_O(lamp), .RUN_ENABLE_O(run),
        .OUTPUTS_O(outs));
    css_flash_model flash_u (.clk_i(clk), .rst_i(rst), .wr_i(fwr), .rd_i(frd),
        .slow_i(slow), .fail_cmd_i(fail_cmd), .done_o(fdone), .fail_o(ffail));

    // 40 MHz clock
    always #12.5 clk = ~clk;
    // words written to flash, counted for backup length checks
    always @(posedge clk) if (fdone && fwr) wdone <= wdone + 1;

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk32(rd, exp);
    endtask
    // bounded wait on the lamp, then compare it
    task automatic wait_lamp(input logic v, input int lim);
        int k;
        k = 0;
        while (lamp !== v && k < lim) begin
            @(posedge clk);
            k++;
        end
        chk1(lamp, v);
    endtask
    task automatic err(input logic [15:0] c);
        @(posedge clk);
        sys_err <= 1'b1;
        code <= c;
        tm <= {16'h7000, c};
        @(posedge clk);
        sys_err <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic pulse_prog(input int len);
        @(posedge clk);
        prog_wr <= 1'b1;
        repeat (len) @(posedge clk);
        prog_wr <= 1'b0;
    endtask
    task automatic results;
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // hang guard, well above the expected few thousand cycles
    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        results();
    end

    initial begin
        // startup settings: each pass powers up again under one setting pair
        for (int c = 0; c < 3; c++) begin
            @(posedge clk);
            rst <= 1'b1;
            units <= 1'b0;
            boards <= 1'b0;
            repeat (16) @(posedge clk);
            rst <= 1'b0;
            apb(1'b1, `CSS_ADDR_CTRL, {28'h0, cfg[c], 2'h0});
            chk1(lamp, 1'b1);
            chk1(frd, 1'b1);
            chk1(run, 1'b0);
            wait_lamp(1'b0, 3000);
            chk32({16'h0, faddr}, {16'h0, `CSS_RESTORE_WORDS});
            for (int s = 0; s < 3; s++) begin
                units <= (s == 2);
                boards <= (s >= 1);
                repeat (4) @(posedge clk);
                chk1(run, cfg[c][0] ? (cfg[c][1] | boards) : (units & boards));
            end
        end
        // forced off and mode change; settings kept at 0x0c
        repeat (3) @(posedge clk);
        chk32({16'h0, outs}, 32'ha5c3);
        // software blanks outputs this way, e.g. while the battery has failed
        apb(1'b1, `CSS_ADDR_CTRL, 32'h0d);
        repeat (3) @(posedge clk);
        chk32({16'h0, outs}, 32'h0);
        chk1(run, 1'b1);
        apb(1'b1, `CSS_ADDR_CTRL, 32'h0c);
        mode <= 2'h0;
        repeat (3) @(posedge clk);
        chk32({16'h0, outs}, 32'h0);
        mode <= 2'h1;
        apb(1'b1, `CSS_ADDR_CTRL, 32'h1c);
        mode <= 2'h0;
        repeat (3) @(posedge clk);
        chk32({16'h0, outs}, 32'ha5c3);
        mode <= 2'h1;
        apb(1'b1, `CSS_ADDR_CTRL, 32'h0c);
        // error log: one more error than the log holds
        for (int i = 1; i <= 21; i++) begin
            err(16'h0100 + 16'(i));
            if (i == 1) begin
                rdchk(`CSS_ADDR_DETAIL, 32'hd0000101);
                rdchk(`CSS_ADDR_TIME, 32'h70000101);
                rdchk(`CSS_ADDR_LOGPTR, 32'h1);
                rdchk(`CSS_ADDR_ERRCODE, 32'h0101);
                rdchk(`CSS_ADDR_LOGBASE, 32'h0101);
                rdchk(`CSS_ADDR_LOGBASE + 12'h004, 32'hd0000101);
                rdchk(`CSS_ADDR_LOGBASE + 12'h008, 32'h70000101);
                rdchk(`CSS_ADDR_LOGBASE + 12'h00c, 32'h0);
            end
        end
        rdchk(`CSS_ADDR_LOGPTR, 32'd20);
        rdchk(`CSS_ADDR_LOGBASE, 32'h0102);
        rdchk(`CSS_ADDR_LOGBASE + 12'h168, 32'h0114);
        rdchk(`CSS_ADDR_LOGBASE + 12'h17c, 32'h0115);
        rdchk(12'h0f0, 32'h0);
        chk1(slverr, 1'b0);
        apb(1'b1, `CSS_ADDR_CTRL, 32'h0e);
        rdchk(`CSS_ADDR_LOGPTR, 32'h0);
        // a frozen clock enable must not log anything
        ce <= 1'b0;
        err(16'h0200);
        ce <= 1'b1;
        rdchk(`CSS_ADDR_LOGPTR, 32'h0);
        // user non-fatal alarm keeps the program running
        apb(1'b1, `CSS_ADDR_CTRL, 32'h2c);
        repeat (3) @(posedge clk);
        rdchk(`CSS_ADDR_ERRCODE, {16'h0, `CSS_CODE_FAL});
        rdchk(`CSS_ADDR_LOGPTR, 32'h1);
        apb(1'b1, `CSS_ADDR_CTRL, 32'h0c);
        apb(1'b0, `CSS_ADDR_STAT, 32'h0);
        chk1(rd[`CSS_STAT_NONFATAL], 1'b1);
        chk1(run, 1'b1);
        // backup of five words for program size four, with slow flash answers
        slow <= 1'b1;
        w0 = wdone;
        pulse_prog(3);
        wait_lamp(1'b1, 20);
        wait_lamp(1'b0, 400);
        chk32(32'(wdone - w0), 32'd5);
        chk32({16'h0, faddr}, 32'd5);
        // a new write in mid-backup restarts it
        w0 = wdone;
        pulse_prog(2);
        n = 0;
        while (wdone - w0 < 2 && n < 200) begin
            @(posedge clk);
            n++;
        end
        pulse_prog(1);
        wait_lamp(1'b0, 600);
        chk1(wdone - w0 >= 7, 1'b1);
        // flash failure during a backup
        pulse_prog(2);
        repeat (6) @(posedge clk);
        fail_cmd <= 1'b1;
        @(posedge clk);
        fail_cmd <= 1'b0;
        repeat (4) @(posedge clk);
        apb(1'b0, `CSS_ADDR_STAT, 32'h0);
        chk1(rd[`CSS_STAT_FLASH_ERR], 1'b1);
        // a fresh write leaves the failed state, so run below means something
        pulse_prog(1);
        wait_lamp(1'b1, 20);
        wait_lamp(1'b0, 400);
        chk1(run, 1'b1);
        // user fatal alarm stops execution
        apb(1'b1, `CSS_ADDR_CTRL, 32'h4c);
        repeat (3) @(posedge clk);
        rdchk(`CSS_ADDR_ERRCODE, {16'h0, `CSS_CODE_FALS});
        apb(1'b0, `CSS_ADDR_STAT, 32'h0);
        chk1(rd[`CSS_STAT_HALTED], 1'b1);
        chk1(run, 1'b0);
        // system fatal error logged with its fatal mark, after the user one
        sfatal <= 1'b1;
        err(16'h0300);
        sfatal <= 1'b0;
        rdchk(`CSS_ADDR_ERRCODE, 32'h0300);
        rdchk(`CSS_ADDR_LOGBASE + 12'h020, 32'h1);
        rdchk(`CSS_ADDR_LOGBASE + 12'h034, 32'h1);
        results();
    end
endmodule
